// ---- hw/omc_regs.vh ----
/*
 mute control register map, field positions and codes.
 assumes 8-bit register access with byte offsets as printed.
*/
`ifndef OMC_REGS_VH
`define OMC_REGS_VH
`define OMC_ADDR_PRIMARY 8'h80
`define OMC_ADDR_ACTION 8'h81
`define OMC_RST_PRIMARY 8'h90
`define OMC_RST_ACTION 8'h77
`define OMC_PRIMARY_WMASK 8'hd7
`define OMC_BIT_MASTER_EN 7
`define OMC_BIT_SW_REQ 6
`define OMC_BIT_ALARM_FLAG_CLEAR 5
`define OMC_BIT_HOLD_EN 4
`define OMC_BIT_LEVEL_EN 2
`define OMC_LVL_NONE 2'h0
`define OMC_LVL_FIRST 2'h1
`define OMC_LVL_SECOND 2'h2
`define OMC_LVL_EITHER 2'h3
`define OMC_TYPE_HARD 2'h0
`define OMC_TYPE_HOLD 2'h1
`define OMC_TYPE_SOFT_IQ 2'h2
`define OMC_TYPE_SOFT 2'h3
`endif

// ---- hw/omc_top.v ----
/*
 output mute control: two control registers, cause arbitration and mute type outputs.
 assumes a simple synchronous 8-bit register port and cause inputs from pins or other
 domains, which are synchronised here.
*/
`timescale 1ns/1ns
`include "omc_regs.vh"

// Contract
// - selector 00 gives hard mute plus iq indication; 01 hold plus indication
// - selector 10 gives soft mute plus indication; 11 soft mute only
// - action register holds incident, data-valid, alarm, direct selectors high to low
// - level selector acts only while level detection enable is set
// - level selector 00 none, 01 first, 10 second, 11 either detector
module omc_top (
   // clock and reset
   input wire core_clk_i,
   input wire rst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   // mute causes
   input wire incident_i,
   input wire data_valid_error_i,
   input wire alarm_i,
   input wire level_detector_first_i,
   input wire level_detector_second_i,
   // mute outputs
   output reg hard_silence_o,
   output reg hold_silence_o,
   output reg soft_silence_o,
   output reg iq_silenced_indication_o,
   output reg hold_feature_enable_o,
   output reg alarm_flag_clear_o,
   output reg silence_active_o
);

reg [7:0] silence_control_primary;
reg [7:0] silence_action_config;
wire [4:0] cause_pins;
wire [4:0] sync_b;
reg next_hard;
reg next_hold;
reg next_soft;
reg next_iq;
reg [7:0] next_rdata;
wire write_primary;
wire write_action;
wire [3:0] cause;
wire [3:0] cause_hard;
wire [3:0] cause_hold;
wire [3:0] cause_soft;
wire [3:0] cause_iq;
wire level_hit;
wire master_silence_enable;
wire software_silence_request;
wire level_detection_enable;
wire [1:0] level_detector_select;
wire [1:0] incident_action_select;
wire [1:0] data_valid_action_select;
wire [1:0] alarm_action_select;
wire [1:0] direct_action_select;
genvar g;

////////////////////////////////////////////////////////////////////////////////
// registers

assign write_primary = reg_wr_i & (reg_addr_i == `OMC_ADDR_PRIMARY);
assign write_action = reg_wr_i & (reg_addr_i == `OMC_ADDR_ACTION);

// control registers, reserved and strobe bits read back as zero
always @(posedge core_clk_i or posedge rst_i) begin
   if (rst_i) begin
      silence_control_primary <= `OMC_RST_PRIMARY;
      silence_action_config <= `OMC_RST_ACTION;
   end else begin
      if (write_primary) begin
         silence_control_primary <= reg_wdata_i & `OMC_PRIMARY_WMASK;
      end
      if (write_action) begin
         silence_action_config <= reg_wdata_i;
      end
   end
end

// alarm clear is a one-cycle strobe, never stored
always @(posedge core_clk_i or posedge rst_i) begin
   if (rst_i) begin
      alarm_flag_clear_o <= 1'b0;
   end else begin
      alarm_flag_clear_o <= write_primary & reg_wdata_i[`OMC_BIT_ALARM_FLAG_CLEAR];
   end
end

// read data for the address of the previous cycle
always @* begin
   case (reg_addr_i)
      `OMC_ADDR_PRIMARY: next_rdata = silence_control_primary;
      `OMC_ADDR_ACTION: next_rdata = silence_action_config;
      default: next_rdata = 8'h00;
   endcase
end

always @(posedge core_clk_i or posedge rst_i) begin
   if (rst_i) begin
      reg_rdata_o <= 8'h00;
   end else begin
      reg_rdata_o <= next_rdata;
   end
end

assign master_silence_enable = silence_control_primary[`OMC_BIT_MASTER_EN];
assign software_silence_request = silence_control_primary[`OMC_BIT_SW_REQ];
assign level_detection_enable = silence_control_primary[`OMC_BIT_LEVEL_EN];
assign level_detector_select = silence_control_primary[1:0];
assign incident_action_select = silence_action_config[7:6];
assign data_valid_action_select = silence_action_config[5:4];
assign alarm_action_select = silence_action_config[3:2];
assign direct_action_select = silence_action_config[1:0];

////////////////////////////////////////////////////////////////////////////////
// cause synchronisers

assign cause_pins = {level_detector_second_i, level_detector_first_i, alarm_i,
                     data_valid_error_i, incident_i};

// two flip-flops per pin, only the second one is read
generate
   for (g = 0; g < 5; g = g + 1) begin : g_sync
      reg first_ff;
      reg second_ff;
      always @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            first_ff <= 1'b0;
            second_ff <= 1'b0;
         end else begin
            first_ff <= cause_pins[g];
            second_ff <= first_ff;
         end
      end
      assign sync_b[g] = second_ff;
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// cause arbitration and mute type decode

reg lvl;
always @* begin
   lvl = 1'b0;
   if (level_detection_enable) begin
      case (level_detector_select)
         `OMC_LVL_NONE: lvl = 1'b0;
         `OMC_LVL_FIRST: lvl = sync_b[3];
         `OMC_LVL_SECOND: lvl = sync_b[4];
         `OMC_LVL_EITHER: lvl = sync_b[3] | sync_b[4];
         default: lvl = 1'b0;
      endcase
   end
end
assign level_hit = lvl;

// index 0 direct, 1 alarm, 2 data valid, 3 incident
assign cause[0] = software_silence_request | level_hit;
assign cause[1] = sync_b[2];
assign cause[2] = sync_b[1];
assign cause[3] = sync_b[0];

// per cause decode: dec holds hard, hold, soft, iq from high to low
generate
   for (g = 0; g < 4; g = g + 1) begin : g_cause
      reg [3:0] dec;
      always @* begin
         dec = 4'h0;
         if (master_silence_enable && cause[g]) begin
            case (silence_action_config[2*g +: 2])
               `OMC_TYPE_HARD: dec = 4'h9;
               `OMC_TYPE_HOLD: dec = 4'h5;
               `OMC_TYPE_SOFT_IQ: dec = 4'h3;
               `OMC_TYPE_SOFT: dec = 4'h2;
               default: dec = 4'h9;
            endcase
         end
      end
      assign cause_hard[g] = dec[3];
      assign cause_hold[g] = dec[2];
      assign cause_soft[g] = dec[1];
      assign cause_iq[g] = dec[0];
   end
endgenerate

// simultaneous causes combine, no priority
always @* begin
   next_hard = |cause_hard;
   next_hold = |cause_hold;
   next_soft = |cause_soft;
   next_iq = |cause_iq;
end

////////////////////////////////////////////////////////////////////////////////
// output registers


always @(posedge core_clk_i or posedge rst_i) begin
   if (rst_i) begin
      hard_silence_o <= 1'b0;
      hold_silence_o <= 1'b0;
      soft_silence_o <= 1'b0;
      iq_silenced_indication_o <= 1'b0;
      hold_feature_enable_o <= 1'b0;
      silence_active_o <= 1'b0;
   end else begin
      hard_silence_o <= next_hard;
      hold_silence_o <= next_hold;
      soft_silence_o <= next_soft;
      iq_silenced_indication_o <= next_iq;
      hold_feature_enable_o <= silence_control_primary[`OMC_BIT_HOLD_EN];
      silence_active_o <= next_hard | next_hold | next_soft;
   end
end

endmodule // omc_top

// ---- tb/omc_top_properties.sv ----
/* checker for the omc_top ports.
 assumes a bind onto omc_top. */
`timescale 1ns/1ns
module omc_top_properties (
   input wire core_clk_i, rst_i, reg_wr_i, incident_i, data_valid_error_i, alarm_i,
   input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire hard_silence_o, hold_silence_o, soft_silence_o, iq_silenced_indication_o,
   input wire alarm_flag_clear_o, silence_active_o
);
   reg [7:0] pri;
   reg [2:0] qs;
   wire lv_off = ~pri[6] & (~pri[2] | pri[1:0] == 2'h0);
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pri <= 8'h90;
         qs <= 3'h0;
      end else begin
         if (reg_wr_i && reg_addr_i == 8'h80) pri <= reg_wdata_i;
         qs <= {qs[1:0], ~(incident_i | data_valid_error_i | alarm_i)};
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_r1; hard_silence_o | hold_silence_o |-> iq_silenced_indication_o; endproperty
   a_r1: assert property (p_r1) else $error("iq missing");
   property p_r2; iq_silenced_indication_o |-> silence_active_o; endproperty
   a_r2: assert property (p_r2) else $error("iq alone");
   property p_r3; reg_wr_i && reg_addr_i == 8'h81 ##1 reg_addr_i == 8'h81
      |=> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
   a_r3: assert property (p_r3) else $error("readback");
   property p_r4; &qs && lv_off && $past(lv_off) |-> !silence_active_o; endproperty
   a_r4: assert property (p_r4) else $error("level mute");
   property p_r6; !pri[7] && !$past(pri[7]) |-> !silence_active_o; endproperty
   a_r6: assert property (p_r6) else $error("master off");
   property p_clr; reg_wr_i && reg_addr_i == 8'h80 && reg_wdata_i[5] |=> alarm_flag_clear_o;
   endproperty
   a_clr: assert property (p_clr) else $error("clear pulse");
   c_hard: cover property (hard_silence_o);
   c_hold: cover property (hold_silence_o);
   c_soft: cover property (soft_silence_o && !iq_silenced_indication_o);
endmodule // omc_top_properties
bind omc_top omc_top_properties u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .reg_wr_i(reg_wr_i), .incident_i(incident_i), .data_valid_error_i(data_valid_error_i),
   .alarm_i(alarm_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .hard_silence_o(hard_silence_o),
   .hold_silence_o(hold_silence_o), .soft_silence_o(soft_silence_o),
   .iq_silenced_indication_o(iq_silenced_indication_o),
   .alarm_flag_clear_o(alarm_flag_clear_o), .silence_active_o(silence_active_o));

// ---- tb/output_mute_control_bench.sv ----
/* bench for omc_top.
 assumes the design files are compiled first. */
`timescale 1ns/1ns
module output_mute_control_bench;
   reg core_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg wr = 1'b0;
   reg [7:0] addr = 8'h80;
   reg [7:0] wd = 8'h00;
   reg [2:0] cs = 3'h0;
   reg [1:0] lv = 2'h0;
   wire [7:0] rd;
   wire hd, ho, so, iq, hf, cl, ac;
   wire [3:0] o = {hd, ho, so, iq};
   localparam [15:0] TY = 16'h2359;
   integer mismatches = 0;
   integer cmp_count = 0;
   integer i, j;
   omc_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wd), .reg_rdata_o(rd), .incident_i(cs[2]), .data_valid_error_i(cs[1]),
      .alarm_i(cs[0]), .level_detector_first_i(lv[0]), .level_detector_second_i(lv[1]),
      .hard_silence_o(hd), .hold_silence_o(ho), .soft_silence_o(so),
      .iq_silenced_indication_o(iq), .hold_feature_enable_o(hf), .alarm_flag_clear_o(cl),
      .silence_active_o(ac));
   always #5 core_clk_i = ~core_clk_i;
   task chk(input string n, input [7:0] e, input [7:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task wrr(input [7:0] a, input [7:0] d);
      begin
         @(posedge core_clk_i);
         #1 addr = a;
         wd = d;
         wr = 1'b1;
         @(posedge core_clk_i);
         #1 wr = 1'b0;
      end
   endtask
   task settle;
      begin
         repeat (4) @(posedge core_clk_i);
         #1;
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      settle;
      chk("primary", 8'h90, rd);
      chk("hold_en", 8'h01, hf);
      for (i = 0; i < 4; i = i + 1) begin
         wrr(8'h81, i);
         wrr(8'h80, 8'he0);
         chk("clear", 8'h01, cl);
         settle;
         chk("types", TY[i*4+:4], o);
         chk("clear_end", 8'h00, cl);
         chk("hold_en_off", 8'h00, hf);
         chk("primary_mask", 8'hc0, rd);
      end
      $display("types done");
      wrr(8'h80, 8'h90);
      wrr(8'h81, 8'h1b);
      settle;
      chk("action", 8'h1b, rd);
      for (i = 0; i < 3; i = i + 1) begin
         cs = 3'h4 >> i;
         settle;
         chk("cause", TY[i*4+:4], o);
      end
      cs = 3'h0;
      wrr(8'h55, 8'hff);
      settle;
      chk("unmapped", 8'h00, rd);
      $display("causes done");
      wrr(8'h81, 8'h03);
      for (i = 0; i < 8; i = i + 1) begin
         wrr(8'h80, 8'h80 | i);
         for (j = 1; j < 3; j = j + 1) begin
            lv = j;
            settle;
            chk("level", i[2] && (i & j) != 0, ac);
         end
      end
      $display("level done");
      wrr(8'h80, 8'h47);
      cs = 3'h7;
      lv = 2'h3;
      settle;
      chk("master", 8'h00, ac);
      $display("master done");
      wrap_up;
   end
   initial begin
      #20000;
      mismatches = mismatches + 1;
      wrap_up;
   end
endmodule // output_mute_control_bench
